// [rtl/timer_pkg.sv]
// shared constants for the 16-bit timer/counter
package timer_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    // control field positions
    localparam int BIT_COUNTER_ON = 0;
    localparam int BIT_CLOCK_SOURCE = 1;
    localparam int BIT_SYNC_BYPASS = 2;
    localparam int BIT_OSC_ENABLE = 3;
    localparam int BIT_PRESCALE_LO = 4;
    localparam int BIT_WIDE_ACCESS = 7;
    // writable control bits, bit 6 absent
    localparam logic [7:0] CONTROL_WMASK = 8'hbf;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [2:0] PRESCALE_ZERO = 3'h0;
    // internal tick is the oscillator clock divided by four
    localparam int INTERNAL_DIVIDE = 4;
endpackage

// [rtl/timer16.sv]
// 16-bit timer/counter with apb register access
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps

// Contract
// - the count is two 8-bit byte registers, both readable and writable.
// - an overflow event is raised when the count wraps from ffff to 0000.
// - a special event trigger from the compare unit clears the count.
// - after reset the counter is off with every control bit zero.
// - control bit 7 selects one 16-bit access instead of two byte accesses.
// - control bit 6 ignores writes and reads as zero.
// - the prescale field divides the count clock by 1, 2, 4 or 8.
// - the oscillator enable bit runs or shuts off the low-power oscillator.
// - with external source, sync bypass 1 passes the input raw, 0 synchronises it.
// - with internal source the sync bypass bit is ignored.
// - clock source 1 counts external rising edges, 0 counts the clock over four.
// - in wide mode a low byte read copies the live high byte into a buffer read at high.
// - in wide mode a high write fills the buffer, the low write loads both bytes and clears the prescaler.
// - a low-byte count write wins over a coinciding trigger, a byte-mode high write wins only for the high byte, and the trigger never sets the flag.
// - overflow latches a sticky flag, and the interrupt rises only while enabled.
module timer16 #(
    parameter int INT_DIV = timer_pkg::INTERNAL_DIVIDE
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // count sources
    input wire logic external_count_input,
    input wire logic special_event_trigger,
    // oscillator control and interrupt
    output logic low_power_osc_enable,
    output logic irq
);
    // the divide counter is eight bits wide, so larger ratios cannot be served
    if (INT_DIV < 1 || INT_DIV > 255) begin
        $error("INT_DIV out of range");
    end

    // control and count state
    logic [7:0] counter_control;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] high_buffer;
    logic [2:0] prescale_count;
    logic [7:0] div_count;
    // interrupt state
    logic overflow_flag;
    logic overflow_irq_enable;
    // external input sampling; stage one feeds only stage two
    logic ext_sync1;
    logic ext_sync2;
    logic ext_sync3;
    logic ext_raw_prev;
    // next values of the control and count group
    logic [7:0] next_counter_control;
    logic [7:0] next_count_low;
    logic [7:0] next_count_high;
    logic [7:0] next_high_buffer;
    logic [2:0] next_prescale_count;
    logic [7:0] next_div_count;
    logic next_low_power_osc_enable;
    // next values of the interrupt group
    logic next_overflow_flag;
    logic next_overflow_irq_enable;
    logic next_irq;
    // next values of the bus answer
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    // next values of the sampling stages
    logic next_ext_sync1;
    logic next_ext_sync2;
    logic next_ext_sync3;
    logic next_ext_raw_prev;

    // decoded strobes
    logic setup_phase;
    logic access_done;
    logic wr_control;
    logic wr_low;
    logic wr_high;
    logic wr_status;
    logic wr_mask;
    logic rd_low_setup;
    logic wide_mode;
    logic [1:0] prescale_sel;
    logic int_tick;
    logic ext_edge;
    logic source_tick;
    logic prescale_tick;
    logic [2:0] prescale_mask;
    logic increment;
    logic wrap;

    // known address test
    function automatic logic addr_mapped(input logic [7:0] a);
        return a == timer_pkg::ADDR_CONTROL || a == timer_pkg::ADDR_COUNT_LOW
            || a == timer_pkg::ADDR_COUNT_HIGH || a == timer_pkg::ADDR_STATUS
            || a == timer_pkg::ADDR_MASK;
    endfunction

    // completing write to one register address
    function automatic logic write_hit(input logic done, input logic wr, input logic [7:0] a,
            input logic [7:0] target);
        return done && wr && a == target;
    endfunction

    // apb phase decode; writes take effect only at the completing edge
    always_comb begin
        setup_phase = psel && !penable;
        access_done = psel && penable && pready;
        // one strobe per register, high only at the completing edge
        wr_control = write_hit(access_done, pwrite, paddr, timer_pkg::ADDR_CONTROL);
        wr_low = write_hit(access_done, pwrite, paddr, timer_pkg::ADDR_COUNT_LOW);
        wr_high = write_hit(access_done, pwrite, paddr, timer_pkg::ADDR_COUNT_HIGH);
        wr_status = write_hit(access_done, pwrite, paddr, timer_pkg::ADDR_STATUS);
        wr_mask = write_hit(access_done, pwrite, paddr, timer_pkg::ADDR_MASK);
        // low byte and buffer snapshot taken together at setup, so they pair
        rd_low_setup = setup_phase && !pwrite && paddr == timer_pkg::ADDR_COUNT_LOW;
        wide_mode = counter_control[timer_pkg::BIT_WIDE_ACCESS];
        prescale_sel = counter_control[timer_pkg::BIT_PRESCALE_LO +: 2];
    end

    // count source selection and prescaler tick
    always_comb begin
        int_tick = div_count == 8'(INT_DIV - 1);
        // raw path uses one sample; sync path reads only the second stage on
        if (counter_control[timer_pkg::BIT_SYNC_BYPASS]) begin
            ext_edge = external_count_input && !ext_raw_prev;
        end else begin
            ext_edge = ext_sync2 && !ext_sync3;
        end
        // sync bypass is not consulted on the internal path
        if (counter_control[timer_pkg::BIT_CLOCK_SOURCE]) begin
            source_tick = ext_edge;
        end else begin
            source_tick = int_tick;
        end
        // low prescale bits that must all be set before a count
        prescale_mask = 3'((4'h1 << prescale_sel) - 4'h1);
        prescale_tick = source_tick && (prescale_count & prescale_mask) == prescale_mask;
        // counter_on gates the count but not the free-running divider
        increment = counter_control[timer_pkg::BIT_COUNTER_ON] && prescale_tick;
        wrap = increment && count_low == timer_pkg::BYTE_ONES
            && count_high == timer_pkg::BYTE_ONES;
    end

    // next count, prescaler and control values
    always_comb begin
        next_counter_control = counter_control;
        next_count_low = count_low;
        next_count_high = count_high;
        next_high_buffer = high_buffer;
        next_prescale_count = prescale_count;
        next_div_count = (int_tick) ? timer_pkg::BYTE_ZERO : div_count + 8'h01;
        if (wr_control) begin
            next_counter_control = pwdata[7:0] & timer_pkg::CONTROL_WMASK;
        end
        // pin follows the stored bit, so it moves only with a control write
        next_low_power_osc_enable = next_counter_control[timer_pkg::BIT_OSC_ENABLE];
        // stopped: prescaler and count hold
        if (counter_control[timer_pkg::BIT_COUNTER_ON] && source_tick) begin
            next_prescale_count = prescale_count + 3'h1;
        end
        // carry ripples from low into high in the same step
        if (increment) begin
            {next_count_high, next_count_low} = {count_high, count_low} + 16'h0001;
        end
        // trigger clears the count without touching the flag
        if (special_event_trigger) begin
            next_count_low = timer_pkg::BYTE_ZERO;
            next_count_high = timer_pkg::BYTE_ZERO;
        end
        // snapshot the live high byte for a later high-byte read
        if (rd_low_setup && wide_mode) begin
            next_high_buffer = count_high;
        end
        // software writes come last so they beat the trigger
        if (wr_high) begin
            if (wide_mode) begin
                next_high_buffer = pwdata[7:0];
            end else begin
                next_count_high = pwdata[7:0];
            end
        end
        // low write loads the low byte, in wide mode the whole word, and restarts the prescaler
        if (wr_low) begin
            next_count_low = pwdata[7:0];
            next_prescale_count = timer_pkg::PRESCALE_ZERO;
            if (wide_mode) begin
                next_count_high = high_buffer;
            end else if (special_event_trigger) begin
                next_count_high = count_high;
            end
        end
    end

    // interrupt flag and enable; hardware set beats a write-one clear
    always_comb begin
        next_overflow_flag = overflow_flag;
        next_overflow_irq_enable = overflow_irq_enable;
        // write one clears; the set below overrides it in the same cycle
        if (wr_status && pwdata[0]) begin
            next_overflow_flag = 1'b0;
        end
        // a wide high write only fills the buffer, so a wrap then still counts
        if (wrap && !(special_event_trigger || wr_low || (wr_high && !wide_mode))) begin
            next_overflow_flag = 1'b1;
        end
        if (wr_mask) begin
            next_overflow_irq_enable = pwdata[0];
        end
        // level request from the post-edge state, so it rises with the flag
        next_irq = next_overflow_flag && next_overflow_irq_enable;
    end

    // read mux and zero-wait answer built at the setup edge
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pready = setup_phase;
        next_pslverr = setup_phase && !addr_mapped(paddr);
        if (setup_phase && !pwrite) begin
            case (paddr)
                timer_pkg::ADDR_CONTROL: next_prdata[7:0] = counter_control;
                timer_pkg::ADDR_COUNT_LOW: next_prdata[7:0] = count_low;
                timer_pkg::ADDR_COUNT_HIGH: begin
                    next_prdata[7:0] = wide_mode ? high_buffer : count_high;
                end
                // unused status and mask bits read as zero
                timer_pkg::ADDR_STATUS: next_prdata[0] = overflow_flag;
                timer_pkg::ADDR_MASK: next_prdata[0] = overflow_irq_enable;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // registers; all control cleared at reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_control <= timer_pkg::CONTROL_RESET;
            count_low <= timer_pkg::BYTE_ZERO;
            count_high <= timer_pkg::BYTE_ZERO;
            high_buffer <= timer_pkg::BYTE_ZERO;
            prescale_count <= timer_pkg::PRESCALE_ZERO;
            div_count <= timer_pkg::BYTE_ZERO;
            overflow_flag <= 1'b0;
            overflow_irq_enable <= 1'b0;
            // bus answer idle until the first setup
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            low_power_osc_enable <= 1'b0;
            irq <= 1'b0;
        end else begin
            counter_control <= next_counter_control;
            count_low <= next_count_low;
            count_high <= next_count_high;
            high_buffer <= next_high_buffer;
            prescale_count <= next_prescale_count;
            div_count <= next_div_count;
            overflow_flag <= next_overflow_flag;
            overflow_irq_enable <= next_overflow_irq_enable;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            // oscillator and interrupt pins
            low_power_osc_enable <= next_low_power_osc_enable;
            irq <= next_irq;
        end
    end

    // sampling stages; only stage two reads stage one
    always_comb begin
        next_ext_sync1 = external_count_input;
        next_ext_sync2 = ext_sync1;
        next_ext_sync3 = ext_sync2;
        next_ext_raw_prev = external_count_input;
    end

    // external input sampling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_sync3 <= 1'b0;
            ext_raw_prev <= 1'b0;
        end else begin
            ext_sync1 <= next_ext_sync1;
            ext_sync2 <= next_ext_sync2;
            ext_sync3 <= next_ext_sync3;
            ext_raw_prev <= next_ext_raw_prev;
        end
    end
endmodule

// [tb/ext_count_src.sv]
// external count source model driving the count pin
`timescale 1ns/10ps
module ext_count_src (
    // clock
    input wire logic clk,
    // count pin, idle low between bursts
    output logic pin
);
    initial pin = 1'b0;
    // n rising edges, two cycles high and three low, synchronous to clk
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge clk) pin <= 1'b1;
            repeat (2) @(posedge clk);
            pin <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// [tb/timer16_asserts.sv]
// port assertions for the timer/counter
`timescale 1ns/10ps
module timer16_asserts #(
    parameter int INT_DIV = timer_pkg::INTERNAL_DIVIDE
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // other pins
    input wire logic external_count_input,
    input wire logic special_event_trigger,
    input wire logic low_power_osc_enable,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic setup, wr_ctl, mapped;
    // decoded bus phases
    assign setup = psel && !penable;
    assign wr_ctl = psel && penable && pready && pwrite && paddr == timer_pkg::ADDR_CONTROL;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= timer_pkg::ADDR_MASK;
    AST_READY_NEXT: assert property (setup |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_UNMAPPED: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    AST_BIT6: assert property (setup && !pwrite && paddr == timer_pkg::ADDR_CONTROL
        |=> prdata[31:8] == 24'h0 && !prdata[6])
        else $error("control unused bits not zero");
    AST_OSC_VAL: assert property (wr_ctl |=> low_power_osc_enable == $past(pwdata[3]))
        else $error("osc enable not taken");
    AST_OSC_HOLD: assert property (!$stable(low_power_osc_enable) |-> $past(wr_ctl))
        else $error("osc enable moved alone");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("irq dropped without a write");
    // main scenarios reached
    cover property (irq);
    cover property (pslverr);
    cover property (wr_ctl ##1 low_power_osc_enable);
endmodule

bind timer16 timer16_asserts #(.INT_DIV(INT_DIV)) u_asserts (.clk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_count_input,
    .special_event_trigger, .low_power_osc_enable, .irq);

// [tb/tb.sv]
// self-checking bench for the timer/counter
`timescale 1ns/10ps
module tb;
    logic clk, reset_n, psel, penable, pwrite, trig, err, pready, pslverr, pin, osc, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_mismatch, n_compared;
    localparam logic [7:0] CTL = timer_pkg::ADDR_CONTROL;
    localparam logic [7:0] LO = timer_pkg::ADDR_COUNT_LOW;
    localparam logic [7:0] HI = timer_pkg::ADDR_COUNT_HIGH;
    localparam logic [7:0] ST = timer_pkg::ADDR_STATUS;
    localparam logic [7:0] MK = timer_pkg::ADDR_MASK;
    // device and count source
    timer16 uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_count_input(pin), .special_event_trigger(trig),
        .low_power_osc_enable(osc), .irq);
    ext_count_src src (.clk, .pin);
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_sim;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // registered outputs settle one edge after the write
    task automatic pins(input logic eo, input logic ei);
        @(posedge clk);
        chk({30'h0, osc, irq}, {30'h0, eo, ei});
    endtask
    task automatic t_ctrl;
        pins(1'b0, 1'b0);
        rdc(CTL, 32'h0);
        wr(CTL, 32'hff);
        rdc(CTL, 32'hbf);
        pins(1'b1, 1'b0);
        wr(CTL, 32'h0);
        pins(1'b0, 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask
    // internal source, all four divide ratios, sync bypass set but ignored
    task automatic t_prescale;
        for (int k = 0; k < 4; k++) begin
            wr(LO, 32'h0);
            wr(CTL, {26'h0, k[1:0], 4'h5});
            repeat (32 << k) @(posedge clk);
            wr(CTL, 32'h0);
            apb(1'b0, LO, 32'h0);
            chk({31'h0, rd >= 8 && rd <= 9}, 32'h1);
        end
    endtask
    // external edges, synchronised and raw; stopped counter holds
    task automatic t_external;
        for (int b = 0; b < 2; b++) begin
            wr(LO, 32'h0);
            wr(CTL, {29'h0, b[0], 2'h3});
            src.burst(5);
            wr(CTL, {29'h0, b[0], 2'h2});
            src.burst(3);
            rdc(LO, 32'h5);
        end
    endtask
    task automatic t_overflow;
        wr(MK, 32'h1);
        wr(HI, 32'hff);
        wr(LO, 32'hfe);
        wr(CTL, 32'h7);
        src.burst(1);
        pins(1'b0, 1'b0);
        src.burst(1);
        pins(1'b0, 1'b1);
        wr(CTL, 32'h0);
        rdc(HI, 32'h0);
        wr(MK, 32'h0);
        pins(1'b0, 1'b0);
        rdc(ST, 32'h1);
        wr(MK, 32'h1);
        pins(1'b0, 1'b1);
        wr(ST, 32'h1);
        pins(1'b0, 1'b0);
    endtask
    // trigger clears, sets no flag, loses to a coinciding write
    task automatic t_trigger;
        wr(HI, 32'h12);
        @(posedge clk) trig <= 1'b1;
        @(posedge clk) trig <= 1'b0;
        rdc(HI, 32'h0);
        rdc(ST, 32'h0);
        fork
            wr(LO, 32'h56);
            begin
                repeat (2) @(posedge clk);
                trig <= 1'b1;
                @(posedge clk) trig <= 1'b0;
            end
        join
        rdc(LO, 32'h56);
    endtask
    task automatic t_wide;
        wr(CTL, 32'h80);
        wr(HI, 32'hab);
        wr(LO, 32'hcd);
        wr(HI, 32'h00);
        wr(CTL, 32'h0);
        rdc(HI, 32'hab);
        rdc(LO, 32'hcd);
        wr(LO, 32'hff);
        wr(HI, 32'h0);
        wr(CTL, 32'h87);
        rdc(LO, 32'hff);
        src.burst(1);
        rdc(HI, 32'h0);
        rdc(LO, 32'h0);
        rdc(HI, 32'h1);
        // wrap coinciding with a wide high write still flags
        wr(HI, 32'hff);
        wr(LO, 32'hff);
        fork
            wr(HI, 32'h22);
            begin
                @(posedge clk);
                src.burst(1);
            end
        join
        rdc(ST, 32'h1);
        rdc(LO, 32'h0);
    endtask
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        {reset_n, psel, penable, pwrite, trig} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_ctrl();
        t_prescale();
        t_external();
        t_overflow();
        t_trigger();
        t_wide();
        end_sim();
    end
    // hang limit
    initial begin
        #2000000;
        n_mismatch++;
        end_sim();
    end
endmodule
